// File: hdl/nvt_pkg.sv
// package: register map, field positions, classes and decode enums
package nvt_pkg;
    // register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] OFF_CFG_LO = 8'h00;
    localparam logic [7:0] OFF_CFG_HI = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;

    // reset values
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // hyp_config_reg bit positions and their place in the high word
    localparam int NV_CTRL_BIT = 42;
    localparam int NV_AUX_BIT = 43;
    localparam int AT_TRAP_BIT = 44;
    localparam int NV_REDIR_BIT = 45;
    localparam int NV_CTRL_POS = NV_CTRL_BIT - 32;
    localparam int NV_AUX_POS = NV_AUX_BIT - 32;
    localparam int AT_TRAP_POS = AT_TRAP_BIT - 32;
    localparam int NV_REDIR_POS = NV_REDIR_BIT - 32;

    // control register fields
    localparam int CTRL_HYP_EN = 0;
    localparam int CTRL_SEC_CALL_TRAP = 1;
    localparam int CTRL_HIER_PERM = 2;
    localparam int CTRL_MON_PRESENT = 3;
    localparam int CTRL_MIX_LO = 4;
    localparam int CTRL_MIX_HI = 5;

    // status register fields
    localparam int ST_NV_EFF = 0;
    localparam int ST_AUX_EFF = 1;
    localparam int ST_REDIR_EFF = 2;
    localparam int ST_TRAP_SEEN = 3;
    localparam int ST_EC_LO = 8;

    // exception classes and fixed values
    localparam logic [5:0] EC_SYSREG = 6'h18;
    localparam logic [5:0] EC_SEC_CALL = 6'h17;
    localparam logic [5:0] EC_EXC_RETURN = 6'h1a;
    localparam logic [5:0] EC_PTR_AUTH = 6'h09;
    localparam logic [7:0] CURLVL_VALUE = 8'h02;
    localparam logic [1:0] SPSR_M32_NESTED = 2'h2;
    localparam logic [1:0] SPSR_M32_PLAIN = 2'h1;

    // descriptor bit positions
    localparam int BLK_PXN_BIT = 54;
    localparam int BLK_RSVD_BIT = 53;
    localparam int TBL_PXN_BIT = 60;
    localparam int TBL_RSVD_BIT = 59;
    localparam logic [63:0] BLK_ZERO_MASK = 64'h0000_0000_0000_0040;
    localparam logic [63:0] TBL_ZERO_MASK = 64'h2000_0000_0000_0000;

    // choice for aux=1, main=0
    typedef enum logic [1:0] {
        MIX_AS_BOTH_SET,
        MIX_AS_BOTH_CLEAR,
        MIX_LITERAL,
        MIX_LITERAL_ALT
    } mix_mode_t;

    typedef enum logic [3:0] {
        INS_NONE,
        INS_SYSREG_RD,
        INS_SYSREG_WR,
        INS_AT_S1,
        INS_AT_HYP,
        INS_TLBI_HYP,
        INS_TLBI_HIGH,
        INS_SMC,
        INS_EXCEPTION_RETURN,
        INS_AUTH_EXCEPTION_RETURN_A,
        INS_AUTH_EXCEPTION_RETURN_B,
        INS_LD_UNPRIV,
        INS_ST_UNPRIV
    } insn_class_t;

    typedef enum logic [3:0] {
        GRP_NONE,
        GRP_HYP,
        GRP_HYP_SP,
        GRP_HYP_SPSR,
        GRP_HYP_ELR,
        GRP_HYP_ESR,
        GRP_HYP_FAR,
        GRP_CROSS,
        GRP_USER_CROSS,
        GRP_BANKED,
        GRP_KERNEL_SP,
        GRP_VBAR,
        GRP_ELR_K,
        GRP_SPSR_K,
        GRP_SCXT,
        GRP_CURLVL
    } sysreg_grp_t;
endpackage

// File: hdl/desc_fix.sv
// descriptor reinterpretation for the kernel regime under nesting
`timescale 1ns/100ps
`default_nettype none
module desc_fix import nvt_pkg::*; (
    // controls
    input wire logic en_in,
    input wire logic table_in,
    input wire logic hier_in,
    // descriptor
    input wire logic [63:0] desc_in,
    output logic [63:0] desc_out,
    output logic pxn_out,
    output logic rsvd_out
);
    wire logic blk_fix = en_in & ~table_in;
    wire logic tbl_fix = en_in & table_in & hier_in;

    assign desc_out = blk_fix ? (desc_in & ~BLK_ZERO_MASK) :
                      tbl_fix ? (desc_in & ~TBL_ZERO_MASK) : desc_in;
    assign pxn_out = blk_fix ? desc_in[BLK_PXN_BIT] :
                     tbl_fix ? desc_in[TBL_PXN_BIT] : 1'b0;
    assign rsvd_out = blk_fix ? desc_in[BLK_RSVD_BIT] :
                      tbl_fix ? desc_in[TBL_RSVD_BIT] : 1'b0;
endmodule // desc_fix
`default_nettype wire

// File: hdl/nested_virt_trap_control.sv
// nested virtualization trap, transform and redirect decisions
// Contract
// (RQ1) address-translation trap bit traps six AT, 0x18
// (RQ2) control bits need no known reset value
// (RQ3) aux 0, redirect+main: hyp/cross regs become memory
// (RQ4) aux 1, redirect: hyp regs become memory
// (RQ5) aux 1, no redirect: four kernel regs trap
// (RQ6) memory transform beats own register traps
// (RQ7) other control traps beat memory transform
// (RQ8) unimplemented listed register is undefined
// (RQ9) aux 0, main 1: kernel exceptions write 0b10
// (RQ10) both set: block descriptors bits remapped
// (RQ11) both set, hierarchical: table descriptor bits remapped
// (RQ12) both set: privileged-access-never acts as zero
// (RQ13) both set: unprivileged loads/stores act ordinary
// (RQ14) aux 1, main 0: one of three behaviours
// (RQ15) main 0: redirect ignored, main traps nothing
// (RQ16) main+redirect: hyp status regs steered to kernel
// (RQ17) main, no redirect: hyp-style registers trap 0x18
// (RQ18) main, no redirect: hyp maintenance instructions trap
// (RQ19) main, no redirect: current level reads 0x2
// (RQ20) main, no monitor, secure-call trap: 0x17
// (RQ21) main, no redirect: exception returns trap 0x1a
// (RQ22) exception-return trap wins over pointer-auth trap
// (RQ23) decision returned one cycle after decode request
`timescale 1ns/100ps
`default_nettype none
module nested_virt_trap_control import nvt_pkg::*; (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // decode request
    input wire logic req_valid_in,
    input wire logic kernel_level_in,
    input wire insn_class_t insn_in,
    input wire sysreg_grp_t grp_in,
    input wire logic sysreg_impl_in,
    input wire logic other_trap_in,
    input wire logic [5:0] other_ec_in,
    input wire logic ptr_auth_trap_in,
    // decode answer
    output logic rsp_valid_out,
    output logic trap_out,
    output logic [5:0] trap_ec_out,
    output logic undef_out,
    output logic mem_xform_out,
    output logic redirect_out,
    output logic [1:0] redirect_sel_out,
    output logic curlvl_ovr_out,
    output logic [7:0] curlvl_val_out,
    output logic unpriv_as_priv_out,
    // steady controls
    output logic pan_zero_out,
    output logic [1:0] spsr_m32_out,
    // descriptor path
    input wire logic desc_valid_in,
    input wire logic desc_kernel_in,
    input wire logic desc_table_in,
    input wire logic [63:0] desc_in,
    output logic desc_valid_out,
    output logic [63:0] desc_out,
    output logic desc_pxn_out,
    output logic desc_rsvd_out
);
    function automatic logic hyp_reg(input sysreg_grp_t g);
        hyp_reg = (g == GRP_HYP) || (g == GRP_HYP_SPSR) ||
                  (g == GRP_HYP_ELR) || (g == GRP_HYP_ESR) ||
                  (g == GRP_HYP_FAR);
    endfunction

    function automatic logic steered_reg(input sysreg_grp_t g);
        steered_reg = (g == GRP_HYP_SPSR) || (g == GRP_HYP_ELR) ||
                      (g == GRP_HYP_ESR) || (g == GRP_HYP_FAR);
    endfunction

    logic [31:0] cfg_lo_ff;
    logic [31:0] cfg_hi_ff;
    logic [7:0] ctrl_ff;
    logic trap_seen_ff;
    logic [5:0] last_ec_ff;

    // register decode
    wire logic sel_lo = (addr_in == OFF_CFG_LO);
    wire logic sel_hi = (addr_in == OFF_CFG_HI);
    wire logic sel_ctrl = (addr_in == OFF_CTRL);
    wire logic sel_st = (addr_in == OFF_STATUS);

    // raw stored controls
    wire logic nv_raw = cfg_hi_ff[NV_CTRL_POS];
    wire logic aux_raw = cfg_hi_ff[NV_AUX_POS];
    wire logic at_bit = cfg_hi_ff[AT_TRAP_POS];
    wire logic redir_raw = cfg_hi_ff[NV_REDIR_POS];
    wire logic hyp_en = ctrl_ff[CTRL_HYP_EN];
    wire logic sec_call_trap = ctrl_ff[CTRL_SEC_CALL_TRAP];
    wire logic hier_perm = ctrl_ff[CTRL_HIER_PERM];
    wire logic mon_present = ctrl_ff[CTRL_MON_PRESENT];
    wire mix_mode_t mix = mix_mode_t'(ctrl_ff[CTRL_MIX_HI:CTRL_MIX_LO]);

    // effective controls; config readback stays raw, status reads effective
    wire logic mixed = aux_raw & ~nv_raw;
    wire logic nv_eff = mixed ? (mix == MIX_AS_BOTH_SET) : nv_raw; // [RQ14]
    wire logic aux_eff = mixed ? (mix != MIX_AS_BOTH_CLEAR) : aux_raw;
    wire logic redir_eff = redir_raw & nv_eff; // [RQ15]
    wire logic both_set = nv_eff & aux_eff;

    // request classification
    wire logic is_k = req_valid_in & kernel_level_in;
    wire logic is_reg = (insn_in == INS_SYSREG_RD) ||
                        (insn_in == INS_SYSREG_WR);
    wire logic kreg = is_k & is_reg;
    wire logic is_exception_return = (insn_in == INS_EXCEPTION_RETURN) ||
                         (insn_in == INS_AUTH_EXCEPTION_RETURN_A) ||
                         (insn_in == INS_AUTH_EXCEPTION_RETURN_B);
    wire logic is_auth_exception_return = (insn_in == INS_AUTH_EXCEPTION_RETURN_A) ||
                              (insn_in == INS_AUTH_EXCEPTION_RETURN_B);
    wire logic is_maint = (insn_in == INS_AT_HYP) ||
                          (insn_in == INS_TLBI_HYP) ||
                          (insn_in == INS_TLBI_HIGH);
    wire logic nv_trap_en = is_k & nv_eff & ~redir_eff & hyp_en;
    wire logic aux_trap_en = is_k & aux_eff & ~redir_eff & hyp_en;

    wire logic w_undef = kreg & (grp_in != GRP_NONE) & ~sysreg_impl_in; // [RQ8]
    wire logic w_other = is_k & other_trap_in & ~w_undef;
    wire logic w_redirect = kreg & redir_eff & steered_reg(grp_in) &
                            ~w_undef & ~w_other; // [RQ16]
    wire logic xform_grp = aux_eff ? hyp_reg(grp_in) : // [RQ4]
                           (hyp_reg(grp_in) || (grp_in == GRP_CROSS) ||
                            (grp_in == GRP_USER_CROSS)); // [RQ3]
    wire logic w_xform = kreg & redir_eff & xform_grp & ~w_undef &
                         ~w_other & ~w_redirect; // [RQ7]

    wire logic t_at = is_k & (insn_in == INS_AT_S1) & at_bit & hyp_en; // [RQ1]
    wire logic t_aux_reg = aux_trap_en & is_reg &
                           ((grp_in == GRP_VBAR) || (grp_in == GRP_ELR_K) ||
                            (grp_in == GRP_SPSR_K) ||
                            (grp_in == GRP_SCXT)); // [RQ5]
    wire logic t_nv_reg = nv_trap_en & is_reg &
                          (hyp_reg(grp_in) || (grp_in == GRP_CROSS) ||
                           (grp_in == GRP_USER_CROSS) ||
                           (grp_in == GRP_BANKED) ||
                           (grp_in == GRP_KERNEL_SP)); // [RQ17]
    wire logic t_maint = nv_trap_en & is_maint; // [RQ18]
    wire logic t_smc = nv_trap_en & (insn_in == INS_SMC) & ~mon_present &
                       sec_call_trap; // [RQ20]
    wire logic t_exception_return = nv_trap_en & is_exception_return; // [RQ21]
    wire logic t_pa = is_k & is_auth_exception_return & ptr_auth_trap_in & ~t_exception_return; // [RQ22]
    wire logic own_trap = t_at | t_aux_reg | t_nv_reg | t_maint | t_smc |
                          t_exception_return | t_pa;
    wire logic own_ok = own_trap & ~w_undef & ~w_redirect & ~w_xform; // [RQ6]
    wire logic w_trap = w_other | own_ok;
    wire logic [5:0] own_ec = t_smc ? EC_SEC_CALL :
                              t_exception_return ? EC_EXC_RETURN : // [RQ22]
                              t_pa ? EC_PTR_AUTH : EC_SYSREG;
    wire logic [5:0] w_ec = w_other ? other_ec_in :
                            (own_ok ? own_ec : 6'h00);
    wire logic w_curlvl = nv_trap_en & (insn_in == INS_SYSREG_RD) &
                          (grp_in == GRP_CURLVL) & ~w_undef & ~w_other; // [RQ19]
    wire logic w_unpriv = is_k & both_set &
                          ((insn_in == INS_LD_UNPRIV) ||
                           (insn_in == INS_ST_UNPRIV)); // [RQ13]
    wire logic [1:0] w_sel = (grp_in == GRP_HYP_SPSR) ? 2'h0 :
                             (grp_in == GRP_HYP_ELR) ? 2'h1 :
                             (grp_in == GRP_HYP_ESR) ? 2'h2 : 2'h3;

    // register readback
    wire logic [31:0] status_word = {18'h0_0000, last_ec_ff, 4'h0,
                                     trap_seen_ff, redir_eff, aux_eff, nv_eff};
    wire logic [31:0] rd_mux = sel_lo ? cfg_lo_ff :
                               sel_hi ? cfg_hi_ff :
                               sel_ctrl ? {24'h00_0000, ctrl_ff} :
                               sel_st ? status_word : 32'h0000_0000;
    wire logic st_clear = wr_in & sel_st & wdata_in[ST_TRAP_SEEN];
    wire logic nxt_trap_seen = w_trap | (trap_seen_ff & ~st_clear);

    // descriptor rewrite
    logic [63:0] fix_desc;
    logic fix_pxn;
    logic fix_rsvd;
    desc_fix u_desc_fix (
        .en_in(both_set & desc_kernel_in), // [RQ10]
        .table_in(desc_table_in),
        .hier_in(hier_perm), // [RQ11]
        .desc_in(desc_in),
        .desc_out(fix_desc),
        .pxn_out(fix_pxn),
        .rsvd_out(fix_rsvd)
    );

    // config may be anything after warm reset; cleared anyway [RQ2]
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_lo_ff <= CFG_RESET;
            cfg_hi_ff <= CFG_RESET;
            ctrl_ff <= CTRL_RESET;
        end else if (wr_in) begin
            if (sel_lo) cfg_lo_ff <= wdata_in;
            if (sel_hi) cfg_hi_ff <= wdata_in;
            if (sel_ctrl) ctrl_ff <= wdata_in[7:0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 32'h0000_0000;
            trap_seen_ff <= 1'b0;
            last_ec_ff <= 6'h00;
        end else begin
            rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
            trap_seen_ff <= nxt_trap_seen;
            if (w_trap) last_ec_ff <= w_ec;
        end
    end

    // answer one cycle after the request [RQ23]
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rsp_valid_out <= 1'b0;
            trap_out <= 1'b0;
            trap_ec_out <= 6'h00;
            undef_out <= 1'b0;
            mem_xform_out <= 1'b0;
            redirect_out <= 1'b0;
            redirect_sel_out <= 2'h0;
            curlvl_ovr_out <= 1'b0;
            curlvl_val_out <= 8'h00;
            unpriv_as_priv_out <= 1'b0;
        end else begin
            rsp_valid_out <= req_valid_in;
            trap_out <= w_trap;
            trap_ec_out <= w_ec;
            undef_out <= w_undef;
            mem_xform_out <= w_xform;
            redirect_out <= w_redirect;
            redirect_sel_out <= w_redirect ? w_sel : 2'h0;
            curlvl_ovr_out <= w_curlvl;
            curlvl_val_out <= w_curlvl ? CURLVL_VALUE : 8'h00;
            unpriv_as_priv_out <= w_unpriv;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pan_zero_out <= 1'b0;
            spsr_m32_out <= SPSR_M32_PLAIN;
            desc_valid_out <= 1'b0;
            desc_out <= 64'h0000_0000_0000_0000;
            desc_pxn_out <= 1'b0;
            desc_rsvd_out <= 1'b0;
        end else begin
            pan_zero_out <= both_set; // [RQ12]
            spsr_m32_out <= (nv_eff & ~aux_eff) ? SPSR_M32_NESTED :
                            SPSR_M32_PLAIN; // [RQ9]
            desc_valid_out <= desc_valid_in;
            desc_out <= fix_desc;
            desc_pxn_out <= fix_pxn;
            desc_rsvd_out <= fix_rsvd;
        end
    end

    // checks
    sequence s_kreg;
        req_valid_in && kernel_level_in && is_reg && sysreg_impl_in &&
            !other_trap_in;
    endsequence

    sequence s_kins(insn_class_t c);
        req_valid_in && kernel_level_in && insn_in == c && !other_trap_in;
    endsequence

    property p_at_trap;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_kins(INS_AT_S1) ##0 (at_bit && hyp_en) |=>
            trap_out && trap_ec_out == 6'h18;
    endproperty
    a_at_trap: assert property (p_at_trap) // [RQ1]
        else $error("address translation not trapped");

    property p_xform_cross;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_kreg ##0 (grp_in == GRP_CROSS && redir_raw && nv_raw && !aux_raw)
            |=> mem_xform_out && !trap_out;
    endproperty
    a_xform_cross: assert property (p_xform_cross) // [RQ3]
        else $error("cross-level access not transformed");

    property p_xform_aux;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_kreg ##0 (grp_in == GRP_HYP && redir_eff && aux_eff) |=>
            mem_xform_out;
    endproperty
    a_xform_aux: assert property (p_xform_aux) // [RQ4]
        else $error("hyp access not transformed");

    property p_aux_trap;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_kreg ##0 (grp_in == GRP_VBAR && aux_eff && !redir_eff && hyp_en)
            |=> trap_out && trap_ec_out == 6'h18;
    endproperty
    a_aux_trap: assert property (p_aux_trap) // [RQ5]
        else $error("vector base access not trapped");

    property p_xform_excl;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        mem_xform_out |-> !trap_out && !undef_out && !redirect_out;
    endproperty
    a_xform_excl: assert property (p_xform_excl) // [RQ6]
        else $error("transform overlaps another outcome");

    property p_other_first;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        req_valid_in && kernel_level_in && other_trap_in && !w_undef |=>
            trap_out && !mem_xform_out && trap_ec_out == $past(other_ec_in);
    endproperty
    a_other_first: assert property (p_other_first) // [RQ7]
        else $error("other trap lost to transform");

    property p_undef;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        req_valid_in && kernel_level_in && is_reg && grp_in != GRP_NONE &&
            !sysreg_impl_in |=> undef_out && !trap_out && !mem_xform_out;
    endproperty
    a_undef: assert property (p_undef) // [RQ8]
        else $error("missing register not undefined");

    property p_spsr;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        nv_raw && !aux_raw |=> spsr_m32_out == 2'h2;
    endproperty
    a_spsr: assert property (p_spsr) // [RQ9]
        else $error("saved status mode field wrong");

    property p_pan;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        nv_raw && aux_raw |=> pan_zero_out;
    endproperty
    a_pan: assert property (p_pan) // [RQ12]
        else $error("access-never not forced to zero");

    property p_quiet;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !nv_raw && !aux_raw && !other_trap_in && !ptr_auth_trap_in &&
            insn_in != INS_AT_S1 |=> !trap_out && !mem_xform_out &&
            !redirect_out;
    endproperty
    a_quiet: assert property (p_quiet) // [RQ15]
        else $error("main control off yet acting");

    property p_redirect;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_kreg ##0 (grp_in == GRP_HYP_ESR && redir_eff) |=>
            redirect_out && redirect_sel_out == 2'h2 && !trap_out;
    endproperty
    a_redirect: assert property (p_redirect) // [RQ16]
        else $error("syndrome access not steered");

    property p_curlvl;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_kins(INS_SYSREG_RD) ##0 (grp_in == GRP_CURLVL && sysreg_impl_in
            && nv_eff && !redir_eff && hyp_en) |=>
            curlvl_ovr_out && curlvl_val_out == 8'h02;
    endproperty
    a_curlvl: assert property (p_curlvl) // [RQ19]
        else $error("current level not reported as 0x2");

    property p_smc;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_kins(INS_SMC) ##0 (nv_eff && !redir_eff && hyp_en && !mon_present
            && sec_call_trap) |=> trap_out && trap_ec_out == 6'h17;
    endproperty
    a_smc: assert property (p_smc) // [RQ20]
        else $error("secure call not trapped");

    property p_exception_return_wins;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_kins(INS_AUTH_EXCEPTION_RETURN_B) ##0 (ptr_auth_trap_in && nv_eff && !redir_eff &&
            hyp_en) |=> trap_out && trap_ec_out == 6'h1a;
    endproperty
    a_exception_return_wins: assert property (p_exception_return_wins) // [RQ22]
        else $error("exception return class wrong");
endmodule // nested_virt_trap_control
`default_nettype wire

// File: verif/dec_model.sv
// decode-side model issuing one request per call
`timescale 1ns/100ps
`default_nettype none
module dec_model import nvt_pkg::*; (
    // clock
    input wire logic clk_in,
    // request
    output logic req_out,
    output logic kl_out,
    output insn_class_t insn_out,
    output sysreg_grp_t grp_out,
    output logic impl_out,
    output logic oth_out,
    output logic [5:0] oec_out,
    output logic pa_out
);
    initial begin
        {req_out, kl_out, impl_out, oth_out, pa_out} = 5'h00;
        insn_out = INS_NONE;
        grp_out = GRP_NONE;
        oec_out = 6'h0e;
    end
    task automatic issue(input logic k, input insn_class_t i,
        input sysreg_grp_t g, input logic im, input logic o, input logic p);
        @(posedge clk_in);
        req_out <= 1'b1;
        {kl_out, impl_out, oth_out, pa_out} <= {k, im, o, p};
        insn_out <= i;
        grp_out <= g;
        @(posedge clk_in);
        req_out <= 1'b0;
        insn_out <= INS_NONE;
        {kl_out, impl_out, oth_out, pa_out} <= ~{k, im, o, p};
        #1;
    endtask
endmodule // dec_model
`default_nettype wire

// File: verif/tb_top.sv
// bench for the nested virtualization trap control
`timescale 1ns/100ps
`default_nettype none
module tb_top import nvt_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic req, kl, impl, oth, pa, rv, trap, undef, mx, rdr, cov, upp, panz;
    logic [5:0] oec, ec;
    logic [1:0] rsel, spsr;
    logic [7:0] cval;
    insn_class_t insn;
    sysreg_grp_t grp;
    logic dv = 1'b0, dk = 1'b0, dt = 1'b0, dvo, dpxn, drsv;
    logic [63:0] din = 64'h0, dout;
    int n_fail = 0, n_checks = 0;
    always #25 clk = ~clk;
    dec_model u_dec (.clk_in(clk), .req_out(req), .kl_out(kl),
        .insn_out(insn), .grp_out(grp), .impl_out(impl), .oth_out(oth),
        .oec_out(oec), .pa_out(pa));
    nested_virt_trap_control u_dut (.ref_clk_in(clk), .nrst_in(nrst),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .req_valid_in(req), .kernel_level_in(kl),
        .insn_in(insn), .grp_in(grp), .sysreg_impl_in(impl),
        .other_trap_in(oth), .other_ec_in(oec), .ptr_auth_trap_in(pa),
        .rsp_valid_out(rv), .trap_out(trap), .trap_ec_out(ec),
        .undef_out(undef), .mem_xform_out(mx), .redirect_out(rdr),
        .redirect_sel_out(rsel), .curlvl_ovr_out(cov),
        .curlvl_val_out(cval), .unpriv_as_priv_out(upp),
        .pan_zero_out(panz), .spsr_m32_out(spsr), .desc_valid_in(dv),
        .desc_kernel_in(dk), .desc_table_in(dt), .desc_in(din),
        .desc_valid_out(dvo), .desc_out(dout), .desc_pxn_out(dpxn),
        .desc_rsvd_out(drsv));
    task automatic chk(input string nm, input logic [63:0] s,
        input logic [63:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr_(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cfg(input logic [31:0] hi, input logic [7:0] c);
        wrr(OFF_CFG_HI, hi);
        wrr(OFF_CTRL, {24'h0, c});
        @(posedge clk);
        #1;
    endtask
    task automatic d(input logic k, input insn_class_t i,
        input sysreg_grp_t g, input logic im, input logic o, input logic p,
        input logic t, input logic [5:0] e);
        u_dec.issue(k, i, g, im, o, p);
        chk("rsp", rv, 1'b1);
        chk("trap", trap, t);
        chk("ec", ec, e);
    endtask
    task automatic dsc(input logic tb, input logic [63:0] x);
        @(posedge clk);
        {dv, dk, dt, din} <= {1'b1, 1'b1, tb, x};
        @(posedge clk);
        dv <= 1'b0;
        #1;
    endtask
    task automatic t_regs;
        rdr_(OFF_CFG_HI, v);
        chk("cfg_hi", v, CFG_RESET);
        chk("spsr", spsr, SPSR_M32_PLAIN);
        wrr(OFF_CFG_LO, 32'ha5c3_0f96);
        rdr_(OFF_CFG_LO, v);
        chk("cfg_lo", v, 32'ha5c3_0f96);
        rdr_(8'h10, v);
        chk("unmapped", v, 32'h0);
    endtask
    task automatic t_at;
        cfg(32'h1000, 8'h01);
        d(1, INS_AT_S1, GRP_NONE, 1, 0, 0, 1, EC_SYSREG);
        d(0, INS_AT_S1, GRP_NONE, 1, 0, 0, 0, 6'h00);
        cfg(32'h1000, 8'h00);
        d(1, INS_AT_S1, GRP_NONE, 1, 0, 0, 0, 6'h00);
    endtask
    task automatic t_main;
        cfg(32'h0400, 8'h03);
        chk("spsr", spsr, SPSR_M32_NESTED);
        d(1, INS_AUTH_EXCEPTION_RETURN_A, GRP_NONE, 1, 0, 1, 1, EC_EXC_RETURN);
        d(1, INS_EXCEPTION_RETURN, GRP_NONE, 1, 0, 0, 1, EC_EXC_RETURN);
        d(1, INS_SMC, GRP_NONE, 1, 0, 0, 1, EC_SEC_CALL);
        d(1, INS_TLBI_HIGH, GRP_NONE, 1, 0, 0, 1, EC_SYSREG);
        d(1, INS_SYSREG_WR, GRP_HYP_SP, 1, 0, 0, 0, 6'h00);
        d(1, INS_SYSREG_RD, GRP_BANKED, 1, 0, 0, 1, EC_SYSREG);
        rdr_(OFF_STATUS, v);
        chk("status", v, 32'h1809);
        d(1, INS_SYSREG_RD, GRP_CURLVL, 1, 0, 0, 0, 6'h00);
        chk("curlvl", {cov, cval}, {1'b1, CURLVL_VALUE});
        d(1, INS_SYSREG_RD, GRP_HYP, 0, 0, 0, 0, 6'h00);
        chk("undef", undef, 1'b1);
        cfg(32'h0400, 8'h09);
        d(1, INS_SMC, GRP_NONE, 1, 0, 0, 0, 6'h00);
    endtask
    task automatic t_redir;
        cfg(32'h2400, 8'h01);
        d(1, INS_SYSREG_RD, GRP_HYP_ELR, 1, 0, 0, 0, 6'h00);
        chk("redir", {rdr, rsel}, 3'h5);
        d(1, INS_SYSREG_WR, GRP_CROSS, 1, 0, 0, 0, 6'h00);
        chk("xform", mx, 1'b1);
        d(1, INS_SYSREG_WR, GRP_CROSS, 1, 1, 0, 1, 6'h0e);
        d(1, INS_EXCEPTION_RETURN, GRP_NONE, 1, 0, 0, 0, 6'h00);
    endtask
    task automatic t_both;
        cfg(32'h2c00, 8'h05);
        d(1, INS_SYSREG_RD, GRP_HYP, 1, 0, 0, 0, 6'h00);
        chk("xform", mx, 1'b1);
        d(1, INS_LD_UNPRIV, GRP_NONE, 1, 0, 0, 0, 6'h00);
        chk("unpriv", upp, 1'b1);
        chk("pan", panz, 1'b1);
        dsc(0, 64'h0060_0000_0000_0041);
        chk("blk_v", dvo, 1'b1);
        chk("blk", dout, 64'h0060_0000_0000_0001);
        chk("blk_bits", {dpxn, drsv}, 2'h3);
        dsc(1, 64'h3000_0000_0000_0003);
        chk("tbl", dout, 64'h1000_0000_0000_0003);
        chk("tbl_bits", {dpxn, drsv}, 2'h2);
    endtask
    task automatic t_mix;
        cfg(32'h0800, 8'h21);
        d(1, INS_SYSREG_RD, GRP_VBAR, 1, 0, 0, 1, EC_SYSREG);
        d(1, INS_SYSREG_RD, GRP_HYP, 1, 0, 0, 0, 6'h00);
        cfg(32'h0800, 8'h11);
        d(1, INS_SYSREG_RD, GRP_VBAR, 1, 0, 0, 0, 6'h00);
        cfg(32'h0800, 8'h01);
        d(1, INS_SYSREG_RD, GRP_HYP, 1, 0, 0, 1, EC_SYSREG);
        cfg(32'h2000, 8'h01);
        d(1, INS_SYSREG_RD, GRP_HYP, 1, 0, 0, 0, 6'h00);
        chk("xform", mx, 1'b0);
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_at();
        t_main();
        t_redir();
        t_both();
        t_mix();
        print_verdict();
    end
    initial begin
        #400000;
        n_fail++;
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
